// *** inc/dcd_params.svh ***
// Command codes, register offsets, reset values and frame timing of the command decoder
`ifndef DCD_PARAMS_SVH
`define DCD_PARAMS_SVH
`define DCD_CMD_IDLE_EXIT 8'h38
`define DCD_CMD_IDLE_ENTRY 8'h39
`define DCD_CMD_PIX_FMT 8'h3A
`define DCD_CMD_TEAR_SET 8'h44
`define DCD_CMD_SCAN_RD 8'h45
`define DCD_CMD_BRIGHT_WR 8'h51
`define DCD_CMD_BRIGHT_RD 8'h52
`define DCD_CMD_LUM_WR 8'h53
`define DCD_CMD_LUM_RD 8'h54
`define DCD_CMD_DESC_START 8'hA1
`define DCD_CMD_DESC_CONT 8'hA8
`define DCD_CMD_ID1 8'hDA
`define DCD_CMD_ID2 8'hDB
`define DCD_CMD_ID3 8'hDC
`define DCD_FMT_MASK 8'h77
`define DCD_FMT_RST 8'h70
`define DCD_LUM_MASK 8'h2C
`define DCD_LUM_BRT_EN 5
`define DCD_LUM_DIM_EN 3
`define DCD_LUM_LIT_EN 2
`define DCD_VS 16'h0004
`define DCD_VBP 16'h000C
`define DCD_VACT 16'h0300
`define DCD_VFP 16'h0010
`define DCD_FRAME_LINES (`DCD_VS + `DCD_VBP + `DCD_VACT + `DCD_VFP)
`define DCD_LINE_CLKS_RST 16'h0040
`define DCD_DESC_DEPTH 16'h0010
`define DCD_DESC_AW 4
`define DCD_ESC_EXIT 8'hFF
`define DCD_REG_STATUS 8'h00
`define DCD_REG_LINE 8'h04
`define DCD_REG_DESC 8'h08
`endif

// *** inc/dcd_pkg.sv ***
// Types shared by the command decoder modules
package dcd_pkg;
  typedef enum logic [2:0] {
    ST_CMD = 3'b001,
    ST_PARAM = 3'b010,
    ST_READ = 3'b100
  } dcd_state_t;
endpackage

// *** inc/dcd_link_if.sv ***
// Byte carrier between serial front end and command core
interface dcd_link_if;
  logic byte_valid;
  logic byte_first;
  logic [7:0] byte_data;
  logic tx_start;
  logic [7:0] tx_byte;
  logic tx_done;
  modport rx (output byte_valid, byte_first, byte_data, tx_done, input tx_start, tx_byte);
  modport core (input byte_valid, byte_first, byte_data, tx_done, output tx_start, tx_byte);
endinterface

// *** rtl/dcd_spi_rx.sv ***
// Serial link front end: pin synchronisers, bit shifting and read turnaround
`include "dcd_params.svh"
module dcd_spi_rx (
  input wire logic clk_in, // System clock
  input wire logic nrst_in, // Async reset, low
  input wire logic csx_n_in, // Chip select pin, low
  input wire logic scl_in, // Serial clock pin
  input wire logic sda_in, // Serial data pin level
  output logic sda_out, // Serial data drive value
  output logic sda_oe_n_out, // Low while driving data
  dcd_link_if.rx link // Byte side
);
  logic scl_s1, scl_s2, scl_d, cs_s1, cs_s2, sda_s1, sda_s2;
  logic [2:0] bitcnt_reg;
  logic [7:0] sh_in_reg, sh_out_reg;
  logic first_reg, driving_reg;
  logic rise, fall, active;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      scl_s1 <= 1'b0;
      scl_s2 <= 1'b0;
      scl_d <= 1'b0;
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      sda_s1 <= 1'b0;
      sda_s2 <= 1'b0;
    end else begin
      scl_s1 <= scl_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      cs_s1 <= csx_n_in;
      cs_s2 <= cs_s1;
      sda_s1 <= sda_in;
      sda_s2 <= sda_s1;
    end
  end

  assign rise = scl_s2 & ~scl_d;
  assign fall = ~scl_s2 & scl_d;
  assign active = ~cs_s2;

  // Data and clock share the same sync delay, so sampling stays aligned
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bitcnt_reg <= 3'h0;
      sh_in_reg <= 8'h00;
      first_reg <= 1'b1;
      driving_reg <= 1'b0;
      link.byte_valid <= 1'b0;
      link.byte_first <= 1'b0;
      link.byte_data <= 8'h00;
      link.tx_done <= 1'b0;
    end else begin
      link.byte_valid <= 1'b0;
      link.tx_done <= 1'b0;
      if (!active) begin
        bitcnt_reg <= 3'h0;
        first_reg <= 1'b1;
        driving_reg <= 1'b0;
      end else begin
        if (link.tx_start) begin
          driving_reg <= 1'b1;
        end
        if (rise) begin
          bitcnt_reg <= bitcnt_reg + 3'h1;
          sh_in_reg <= {sh_in_reg[6:0], sda_s2};
          if (bitcnt_reg == 3'h7) begin
            if (driving_reg) begin
              link.tx_done <= 1'b1;
            end else begin
              link.byte_valid <= 1'b1;
              link.byte_first <= first_reg;
              link.byte_data <= {sh_in_reg[6:0], sda_s2};
              first_reg <= 1'b0;
            end
          end
        end
      end
    end
  end

  // Next byte is fetched at the last falling edge of each byte slot
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sh_out_reg <= 8'h00;
    end else if (active && driving_reg && fall) begin
      sh_out_reg <= (bitcnt_reg == 3'h0) ? link.tx_byte : {sh_out_reg[6:0], 1'b0};
    end
  end

  assign sda_out = sh_out_reg[7];
  assign sda_oe_n_out = ~driving_reg;

  property p_turnaround;
    @(posedge clk_in) disable iff (!nrst_in) driving_reg |-> !link.byte_valid;
  endproperty
  a_turnaround: assert property (p_turnaround) else $error("byte taken while driving");
endmodule // dcd_spi_rx

// *** rtl/dcd_top.sv ***
// Display command decoder: serial command core, APB registers, scan, backlight, pixels
//
// The implementer's own choices: the register offsets and the APB register port.
`include "dcd_params.svh"
module dcd_top import dcd_pkg::*; #(
  parameter logic [7:0] MAKER_ID = 8'h5A, // Arbitrary value
  parameter logic [7:0] VERSION_ID = 8'h01, // Arbitrary value
  parameter logic [7:0] MODULE_ID = 8'h3C, // Arbitrary value
  parameter logic [15:0] SUPPLIER_ID = 16'h1234, // Arbitrary value
  parameter logic [15:0] ELECTIVE = 16'h0001 // Arbitrary value
) (
  input wire logic clk_in, // System clock, 40 MHz
  input wire logic nrst_in, // Async reset, low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB write
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input wire logic csx_n_in, // Link chip select, low
  input wire logic scl_in, // Link clock
  input wire logic sda_in, // Link data level
  output logic sda_out, // Link data drive
  output logic sda_oe_n_out, // Link drive enable, low
  input wire logic [23:0] pixel_in, // Pixel from frame memory
  input wire logic fm_write_in, // Frame memory written
  output logic [23:0] pixel_out, // Pixel to panel
  output logic [7:0] pixel_fmt_out, // Active pixel format
  output logic tear_out, // Tear signal
  output logic light_pwm_out, // Backlight drive
  output logic dimming_en_out, // Dimming enable
  output logic idle_mode_out // Idle mode active
);
  dcd_link_if link ();
  dcd_state_t state_reg;
  logic [7:0] cmd_reg, par_idx_reg, fmt_pend_reg, fmt_act_reg, bright_reg, lum_reg;
  logic [7:0] resp, lum_byte, desc_rd, pwm_cnt_reg;
  logic [15:0] rd_idx_reg, tear_line_reg, scan_cap_reg, line_reg, clk_cnt_reg;
  logic [15:0] line_clks_reg, desc_ptr_reg;
  logic [7:0] desc_mem [`DCD_DESC_DEPTH];
  logic idle_reg, tx_start_reg, cmd_in, wr_par, apb_wr, apb_rd;
  logic [23:0] reduced;

  function automatic logic is_read(input logic [7:0] c);
    case (c)
      `DCD_CMD_SCAN_RD, `DCD_CMD_BRIGHT_RD, `DCD_CMD_LUM_RD, `DCD_CMD_DESC_START,
      `DCD_CMD_DESC_CONT, `DCD_CMD_ID1, `DCD_CMD_ID2, `DCD_CMD_ID3: is_read = 1'b1;
      default: is_read = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] param_count(input logic [7:0] c);
    case (c)
      `DCD_CMD_TEAR_SET: param_count = 8'h02;
      `DCD_CMD_PIX_FMT, `DCD_CMD_BRIGHT_WR, `DCD_CMD_LUM_WR: param_count = 8'h01;
      default: param_count = 8'h00;
    endcase
  endfunction

  function automatic logic is_desc(input logic [7:0] c);
    is_desc = (c == `DCD_CMD_DESC_START) || (c == `DCD_CMD_DESC_CONT);
  endfunction

  dcd_spi_rx u_rx (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .csx_n_in(csx_n_in),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n_out(sda_oe_n_out),
    .link(link)
  );

  assign cmd_in = link.byte_valid & link.byte_first;
  assign wr_par = link.byte_valid & ~link.byte_first & (state_reg == ST_PARAM);

  // Any first byte starts a new command, so an aborted one never sticks
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= ST_CMD;
      cmd_reg <= 8'h00;
      par_idx_reg <= 8'h00;
    end else if (cmd_in) begin
      cmd_reg <= link.byte_data;
      par_idx_reg <= 8'h00;
      if (is_read(link.byte_data)) begin
        state_reg <= ST_READ;
      end else if (param_count(link.byte_data) != 8'h00) begin
        state_reg <= ST_PARAM;
      end else begin
        state_reg <= ST_CMD;
      end
    end else if (wr_par) begin
      par_idx_reg <= par_idx_reg + 8'h01;
      if (par_idx_reg + 8'h01 == param_count(cmd_reg)) begin
        state_reg <= ST_CMD;
      end
    end else begin
      case (state_reg)
        ST_CMD, ST_PARAM, ST_READ: state_reg <= state_reg;
        default: state_reg <= ST_CMD;
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tx_start_reg <= 1'b0;
      rd_idx_reg <= 16'h0000;
    end else begin
      tx_start_reg <= cmd_in & is_read(link.byte_data);
      if (cmd_in) begin
        rd_idx_reg <= 16'h0000;
      end else if (link.tx_done) begin
        rd_idx_reg <= rd_idx_reg + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      idle_reg <= 1'b0;
    end else if (cmd_in && link.byte_data == `DCD_CMD_IDLE_ENTRY) begin
      idle_reg <= 1'b1;
    end else if (cmd_in && link.byte_data == `DCD_CMD_IDLE_EXIT) begin
      idle_reg <= 1'b0;
    end
  end

  // Pending format only reaches the panel path on a frame memory write
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      fmt_pend_reg <= `DCD_FMT_RST;
      fmt_act_reg <= `DCD_FMT_RST;
    end else begin
      if (wr_par && cmd_reg == `DCD_CMD_PIX_FMT) begin
        fmt_pend_reg <= link.byte_data & `DCD_FMT_MASK;
      end
      if (fm_write_in) begin
        fmt_act_reg <= fmt_pend_reg;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      tear_line_reg <= 16'h0000;
    end else if (wr_par && cmd_reg == `DCD_CMD_TEAR_SET) begin
      if (par_idx_reg == 8'h00) begin
        tear_line_reg[15:8] <= link.byte_data;
      end else begin
        tear_line_reg[7:0] <= link.byte_data;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      bright_reg <= 8'h00;
      lum_reg <= 8'h00;
    end else if (wr_par && cmd_reg == `DCD_CMD_BRIGHT_WR) begin
      bright_reg <= link.byte_data;
    end else if (wr_par && cmd_reg == `DCD_CMD_LUM_WR) begin
      lum_reg <= link.byte_data & `DCD_LUM_MASK;
    end
  end

  // Line zero is the first sync line; a zero line period is treated as one
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      clk_cnt_reg <= 16'h0000;
      line_reg <= 16'h0000;
      scan_cap_reg <= 16'h0000;
      tear_out <= 1'b0;
    end else begin
      if (clk_cnt_reg + 16'h0001 >= line_clks_reg) begin
        clk_cnt_reg <= 16'h0000;
        line_reg <= (line_reg + 16'h0001 >= `DCD_FRAME_LINES) ? 16'h0000 : line_reg + 16'h0001;
      end else begin
        clk_cnt_reg <= clk_cnt_reg + 16'h0001;
      end
      if (cmd_in && link.byte_data == `DCD_CMD_SCAN_RD) begin
        scan_cap_reg <= line_reg;
      end
      tear_out <= (line_reg == tear_line_reg);
    end
  end

  // Descriptor pointer moves only for bytes fully shifted out
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      desc_ptr_reg <= 16'h0000;
    end else if (cmd_in && link.byte_data == `DCD_CMD_DESC_START) begin
      desc_ptr_reg <= 16'h0000;
    end else if (link.tx_done && is_desc(cmd_reg)) begin
      desc_ptr_reg <= desc_ptr_reg + 16'h0001;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      for (int i = 0; i < `DCD_DESC_DEPTH; i++) begin
        desc_mem[i] <= `DCD_ESC_EXIT;
      end
      desc_mem[0] <= SUPPLIER_ID[7:0];
      desc_mem[1] <= SUPPLIER_ID[15:8];
      desc_mem[2] <= ELECTIVE[7:0];
      desc_mem[3] <= ELECTIVE[15:8];
    end else if (apb_wr && paddr_in == `DCD_REG_DESC) begin
      desc_mem[pwdata_in[8 +: `DCD_DESC_AW]] <= pwdata_in[7:0];
    end
  end

  // Past the stored block the reader keeps seeing the exit code
  assign desc_rd = (desc_ptr_reg < `DCD_DESC_DEPTH) ?
                   desc_mem[desc_ptr_reg[`DCD_DESC_AW-1:0]] : `DCD_ESC_EXIT;
  assign lum_byte = lum_reg & `DCD_LUM_MASK;

  always_comb begin
    case (cmd_reg)
      `DCD_CMD_BRIGHT_RD: resp = bright_reg;
      `DCD_CMD_LUM_RD: resp = lum_byte;
      `DCD_CMD_SCAN_RD: resp = (rd_idx_reg == 16'h0000) ? scan_cap_reg[15:8] :
                                (rd_idx_reg == 16'h0001) ? scan_cap_reg[7:0] : 8'h00;
      `DCD_CMD_DESC_START, `DCD_CMD_DESC_CONT: resp = desc_rd;
      `DCD_CMD_ID1: resp = MAKER_ID;
      `DCD_CMD_ID2: resp = VERSION_ID;
      `DCD_CMD_ID3: resp = MODULE_ID;
      default: resp = 8'h00;
    endcase
  end

  assign link.tx_start = tx_start_reg;
  assign link.tx_byte = resp;

  // Brightness block off means full drive while backlight is on
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pwm_cnt_reg <= 8'h00;
      light_pwm_out <= 1'b0;
    end else begin
      pwm_cnt_reg <= pwm_cnt_reg + 8'h01;
      light_pwm_out <= lum_reg[`DCD_LUM_LIT_EN] &
                       (~lum_reg[`DCD_LUM_BRT_EN] | (pwm_cnt_reg < bright_reg));
    end
  end

  generate
    for (genvar g = 0; g < 3; g++) begin : g_reduce
      assign reduced[g*8 +: 8] = {8{pixel_in[g*8+7]}};
    end
  endgenerate

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      pixel_out <= 24'h000000;
    end else begin
      pixel_out <= idle_reg ? reduced : pixel_in;
    end
  end

  assign pixel_fmt_out = fmt_act_reg;
  assign dimming_en_out = lum_reg[`DCD_LUM_DIM_EN];
  assign idle_mode_out = idle_reg;

  // Zero wait state slave; unmapped addresses answer with an error
  assign pready_out = 1'b1;
  assign apb_wr = psel_in & penable_in & pwrite_in;
  assign apb_rd = psel_in & penable_in & ~pwrite_in;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      line_clks_reg <= `DCD_LINE_CLKS_RST;
    end else if (apb_wr && paddr_in == `DCD_REG_LINE) begin
      line_clks_reg <= pwdata_in[15:0];
    end
  end

  always_comb begin
    prdata_out = 32'h00000000;
    pslverr_out = 1'b0;
    if (apb_wr || apb_rd) begin
      case (paddr_in)
        `DCD_REG_STATUS: prdata_out = {line_reg, bright_reg, lum_byte[7:1], idle_reg};
        `DCD_REG_LINE: prdata_out = {16'h0000, line_clks_reg};
        `DCD_REG_DESC: prdata_out = 32'h00000000;
        default: pslverr_out = 1'b1;
      endcase
    end
  end

  property p_idle_entry;
    @(posedge clk_in) disable iff (!nrst_in)
      cmd_in && link.byte_data == `DCD_CMD_IDLE_ENTRY |=> idle_mode_out ##1 pixel_out == reduced;
  endproperty
  a_idle_entry: assert property (p_idle_entry) else $error("idle entry missed");

  property p_idle_exit;
    @(posedge clk_in) disable iff (!nrst_in)
      cmd_in && link.byte_data == `DCD_CMD_IDLE_EXIT |=> !idle_mode_out;
  endproperty
  a_idle_exit: assert property (p_idle_exit) else $error("idle exit missed");

  property p_idle_repeat;
    @(posedge clk_in) disable iff (!nrst_in)
      cmd_in && link.byte_data == `DCD_CMD_IDLE_ENTRY && idle_reg |=> $stable(idle_reg);
  endproperty
  a_idle_repeat: assert property (p_idle_repeat) else $error("idle state changed");

  property p_fmt_hold;
    @(posedge clk_in) disable iff (!nrst_in) !fm_write_in |=> $stable(pixel_fmt_out);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("format changed early");

  property p_tear;
    @(posedge clk_in) disable iff (!nrst_in) line_reg == tear_line_reg |=> tear_out;
  endproperty
  a_tear: assert property (p_tear) else $error("tear not raised");

  property p_bright;
    @(posedge clk_in) disable iff (!nrst_in)
      wr_par && cmd_reg == `DCD_CMD_BRIGHT_WR |=> bright_reg == $past(link.byte_data);
  endproperty
  a_bright: assert property (p_bright) else $error("brightness not stored");

  property p_light_off;
    @(posedge clk_in) disable iff (!nrst_in) !lum_reg[`DCD_LUM_LIT_EN] [*2] |-> !light_pwm_out;
  endproperty
  a_light_off: assert property (p_light_off) else $error("backlight driven while off");

  property p_desc_start;
    @(posedge clk_in) disable iff (!nrst_in)
      cmd_in && link.byte_data == `DCD_CMD_DESC_START |=> desc_ptr_reg == 16'h0 && tx_start_reg;
  endproperty
  a_desc_start: assert property (p_desc_start) else $error("descriptor start wrong");

  property p_lum_rd;
    @(posedge clk_in) disable iff (!nrst_in)
      cmd_reg == `DCD_CMD_LUM_RD |-> (link.tx_byte & ~`DCD_LUM_MASK) == 8'h00;
  endproperty
  a_lum_rd: assert property (p_lum_rd) else $error("control read reserved bits set");
endmodule // dcd_top

// *** sim/dcd_host_model.sv ***
// Host processor model on the serial command link
module dcd_host_model (
  input wire logic clk_in, // System clock
  input wire logic dev_sda_in, // Device data drive
  input wire logic dev_oe_n_in, // Device drive enable, low
  output logic csx_n_out = 1'b1, // Chip select, low
  output logic scl_out = 1'b0, // Link clock, idles low
  output logic sda_wire_out // Resolved data line
);
  timeunit 1ns;
  timeprecision 1ps;
  logic host_bit = 1'b0;
  logic host_en = 1'b0;
  logic last_lvl = 1'b0;
  logic oe_ok;
  logic [7:0] rx_buf [0:7];
  // No pull on the line: released, it toggles so a stale bit never reads right
  always_comb begin
    if (!dev_oe_n_in) sda_wire_out = dev_sda_in;
    else if (host_en) sda_wire_out = host_bit;
    else sda_wire_out = ~last_lvl;
  end
  always @(posedge clk_in) last_lvl <= sda_wire_out;
  task automatic half();
    repeat (4) @(posedge clk_in);
  endtask
  // Command, npar parameter bytes, then nrd answer bytes
  task automatic frame(input logic [7:0] cmd, input logic [15:0] par, input int npar,
                       input int nrd);
    logic [7:0] b;
    oe_ok = 1'b1;
    @(posedge clk_in);
    csx_n_out <= 1'b0;
    half();
    for (int k = 0; k <= npar; k++) begin
      b = (k == 0) ? cmd : (k < npar) ? par[15:8] : par[7:0];
      for (int i = 7; i >= 0; i--) begin
        host_en <= 1'b1;
        host_bit <= b[i];
        half();
        scl_out <= 1'b1;
        half();
        scl_out <= 1'b0;
      end
    end
    host_en <= 1'b0;
    for (int k = 0; k < nrd; k++) begin
      for (int i = 7; i >= 0; i--) begin
        half();
        scl_out <= 1'b1;
        half();
        // Sampled late in the high phase, clear of the device's change
        rx_buf[k][i] = sda_wire_out;
        if (dev_oe_n_in !== 1'b0) oe_ok = 1'b0;
        scl_out <= 1'b0;
      end
    end
    half();
    csx_n_out <= 1'b1;
    repeat (8) @(posedge clk_in);
  endtask
endmodule // dcd_host_model

// *** sim/tb_top.sv ***
// Self-checking bench of the display command decoder
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SUP_ID = 16'hC3A5; // Arbitrary value
  localparam logic [15:0] ELECT = 16'h0F0E; // Arbitrary value
  localparam logic [7:0] MK_ID = 8'h6B; // Arbitrary value
  localparam logic [7:0] VER_ID = 8'h02; // Arbitrary value
  localparam logic [7:0] MOD_ID = 8'h4D; // Arbitrary value
  logic clk_in, nrst_in, psel_in, penable_in, pwrite_in, pready_out, pslverr_out, err;
  logic csx_n, scl, sda_wire, sda_dev, oe_n, fm_write, tear, light_pwm, dim, idle;
  logic [7:0] paddr_in, fmt;
  logic [31:0] pwdata_in, prdata_out, rd32;
  logic [23:0] pixel_in, pixel_out;
  int fail_count = 0;
  int checks = 0;
  logic [7:0] desc [5] = '{SUP_ID[7:0], SUP_ID[15:8], ELECT[7:0], ELECT[15:8], 8'hFF};
  logic [7:0] id_cmd [3] = '{8'hDA, 8'hDB, 8'hDC};
  logic [7:0] id_exp [3] = '{MK_ID, VER_ID, MOD_ID};
  logic [7:0] bvals [3] = '{8'h00, 8'hA5, 8'hFF};
  logic [7:0] ctls [5] = '{8'hFF, 8'h24, 8'h08, 8'h04, 8'h00};
  logic [15:0] lines [2] = '{16'h0005, 16'h0102};

  dcd_top #(.MAKER_ID(MK_ID), .VERSION_ID(VER_ID), .MODULE_ID(MOD_ID),
    .SUPPLIER_ID(SUP_ID), .ELECTIVE(ELECT)) i_dut (
    .clk_in(clk_in), .nrst_in(nrst_in), .psel_in(psel_in), .penable_in(penable_in),
    .pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in),
    .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .csx_n_in(csx_n), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_dev),
    .sda_oe_n_out(oe_n), .pixel_in(pixel_in), .fm_write_in(fm_write),
    .pixel_out(pixel_out), .pixel_fmt_out(fmt), .tear_out(tear), .light_pwm_out(light_pwm),
    .dimming_en_out(dim), .idle_mode_out(idle));
  dcd_host_model i_host (.clk_in(clk_in), .dev_sda_in(sda_dev), .dev_oe_n_in(oe_n),
    .csx_n_out(csx_n), .scl_out(scl), .sda_wire_out(sda_wire));

  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wrap_up();
    if (fail_count == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // Zero wait states are not assumed: the access phase runs until pready
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clk_in);
    penable_in <= 1'b1;
    do @(posedge clk_in); while (pready_out !== 1'b1);
    rd32 = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  task automatic rdcmd(input logic [7:0] c, input int n);
    i_host.frame(c, 16'h0, 0, n);
    check(i_host.oe_ok, 1'b1);
  endtask
  task automatic fmw();
    @(posedge clk_in);
    fm_write <= 1'b1;
    @(posedge clk_in);
    fm_write <= 1'b0;
    repeat (3) @(posedge clk_in);
  endtask
  task automatic wait_tear(input logic v);
    for (int w = 0; w < 8000 && tear !== v; w++) @(posedge clk_in);
    check(tear, v);
  endtask

  initial begin
    int n;
    nrst_in = 1'b0;
    {psel_in, penable_in, pwrite_in, fm_write} = 4'h0;
    paddr_in = 8'h00;
    pwdata_in = 32'h0;
    pixel_in = 24'h0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(posedge clk_in);
    check(fmt, 8'h70);
    check({idle, dim, light_pwm, oe_n}, 4'h1);
    apb(1'b0, 8'h04, 32'h0);
    check(rd32, 32'h0000_0040);
    apb(1'b0, 8'h10, 32'h0);
    check({err, rd32[30:0]}, 32'h8000_0000);
    pixel_in <= 24'h807FC3;
    for (int k = 0; k < 4; k++) begin
      i_host.frame(k < 2 ? 8'h39 : 8'h38, 16'h0, 0, 0);
      check(idle, k < 2);
      check(pixel_out, k < 2 ? 24'hFF00FF : 24'h807FC3);
    end
    i_host.frame(8'h3A, 16'h00FF, 1, 0);
    check(fmt, 8'h70);
    fmw();
    check(fmt, 8'h77);
    check(fmt[6:4], 3'h7);
    foreach (bvals[k]) begin
      i_host.frame(8'h51, {8'h00, bvals[k]}, 1, 0);
      rdcmd(8'h52, 1);
      check(i_host.rx_buf[0], bvals[k]);
      apb(1'b0, 8'h00, 32'h0);
      check(rd32[15:8], bvals[k]);
    end
    // Half scale makes the drive duty exact over one counter period
    i_host.frame(8'h51, 16'h0080, 1, 0);
    foreach (ctls[k]) begin
      i_host.frame(8'h53, {8'h00, ctls[k]}, 1, 0);
      rdcmd(8'h54, 1);
      check(i_host.rx_buf[0], ctls[k] & 8'h2C);
      check(dim, ctls[k][3]);
      n = 0;
      repeat (256) @(posedge clk_in) n += int'(light_pwm === 1'b1);
      check(n, !ctls[k][2] ? 0 : !ctls[k][5] ? 256 : 128);
    end
    // Short lines keep a frame quick; long ones freeze the count for reading
    apb(1'b1, 8'h04, 32'h8);
    foreach (lines[k]) begin
      i_host.frame(8'h44, lines[k], 2, 0);
      wait_tear(1'b0);
      wait_tear(1'b1);
      apb(1'b1, 8'h04, 32'hFFFF);
      apb(1'b0, 8'h00, 32'h0);
      check(rd32[31:16], lines[k]);
      rdcmd(8'h45, 3);
      check({i_host.rx_buf[0], i_host.rx_buf[1], i_host.rx_buf[2]}, {lines[k], 8'h00});
      apb(1'b1, 8'h04, 32'h8);
    end
    rdcmd(8'hA1, 5);
    foreach (desc[k]) check(i_host.rx_buf[k], desc[k]);
    rdcmd(8'hA1, 2);
    rdcmd(8'hA8, 1);
    check(i_host.rx_buf[0], desc[2]);
    rdcmd(8'hA8, 2);
    check({i_host.rx_buf[0], i_host.rx_buf[1]}, {desc[3], desc[4]});
    // Byte after the exit code patched to an escape code, then read on
    apb(1'b1, 8'h08, 32'h0000_0500);
    rdcmd(8'hA8, 1);
    check(i_host.rx_buf[0], 8'h00);
    foreach (id_cmd[k]) begin
      rdcmd(id_cmd[k], 1);
      check(i_host.rx_buf[0], id_exp[k]);
    end
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge clk_in);
    fail_count++;
    wrap_up();
  end
endmodule // tb_top
